// *** shared/mhf_defs.svh ***
// Purpose: Constants for the host side FIFO controller of the Ethernet device
// Assumes: 16-bit device bus, 8-bit byte address, 32-bit device registers
// Notes: Offsets and bit positions are local choices, see hand-over
`ifndef MHF_DEFS_SVH
`define MHF_DEFS_SVH
// ****************************************
// Device register offsets
// ****************************************
`define MHF_A_RX_DATA 8'h00
`define MHF_A_TX_DATA 8'h20
`define MHF_A_RX_STAT 8'h40
`define MHF_A_RX_CFG 8'h6c
`define MHF_A_TX_CFG 8'h70
`define MHF_A_DP_CTRL 8'h78
`define MHF_A_FIFO_LVL 8'h7c
`define MHF_A_MAC_CR 8'h80
// ****************************************
// Field positions
// ****************************************
`define MHF_B_TX_STOP 0
`define MHF_B_TX_ON 1
`define MHF_B_RX_DUMP 15
`define MHF_B_FFWD 31
`define MHF_B_RECEIVER_ENABLE_BIT 2
`define MHF_F_OFF_LO 8
`define MHF_F_PAD_LO 30
`define MHF_F_STUSED_LO 16
`define MHF_F_LEN_LO 16
// ****************************************
// Reset values and timing
// ****************************************
`define MHF_RST_OFF 5'h00
`define MHF_RST_PAD 2'h0
`define MHF_FFWD_MIN_DW 13'h0004
`define MHF_CLK_NS 20
`define MHF_STROBE_NS 60
`endif

// *** shared/mhf_pkg.sv ***
// Purpose: Types of the host side FIFO controller
// Assumes: Nothing beyond the defs header
// Notes: One-hot state codes
package mhf_pkg;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ACC = 10'h002,
    S_LVL = 10'h004,
    S_STAT = 10'h008,
    S_DATA = 10'h010,
    S_CHK = 10'h020,
    S_POLL = 10'h040,
    S_DONE = 10'h080,
    S_ERR = 10'h100,
    S_SPARE = 10'h200
  } mhf_state_t;
  typedef enum logic [3:0] {
    OP_WR_REG = 4'h0,
    OP_RD_REG = 4'h1,
    OP_TX_WORD = 4'h2,
    OP_TX_STOP = 4'h3,
    OP_TX_START = 4'h4,
    OP_RX_CFG = 4'h5,
    OP_RX_PKT = 4'h6,
    OP_RX_SKIP = 4'h7,
    OP_RX_DUMP = 4'h8
  } mhf_op_t;
endpackage : mhf_pkg

// *** hw/mhf_fifo.sv ***
// Purpose: Receive data FIFO between device reads and the user
// Assumes: Single clock, writer checks in_ready
// Notes: Depth a power of two
`timescale 1ns/1ps
module mhf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mhf_fifo_st_t;
  mhf_fifo_st_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;
  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[q.rp[AW-1:0]];
  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[q.wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : mhf_fifo

// *** hw/mhf_ctrl.sv ***
// Purpose: Host controller driving the Ethernet device FIFOs over its 16-bit bus
// Assumes: Device answers a read within one cycle of strobe; 50 MHz clk
// Notes: One command at a time; receive data leaves through a 16-word FIFO
//
// Overview of operation
// - Host writes both command words per buffer
// - Host sets stop bit; frame completes first
// - Host restarts by setting on bit
// - Never over-read; over-read needs soft reset
// - Start offset 0-31, changed between packets only
// - Optional end padding; length reveals filler
// - Read status, then length+offset+padding data
// - Fast-forward only for four or more DWORDs
// - No FIFO reads while fast-forward pending
// - Dump only after receiver confirmed stopped
// - Receiver stopped by clearing enable bit
`timescale 1ns/1ps
`include "mhf_defs.svh"
module mhf_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire mhf_pkg::mhf_op_t cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  output logic resp_valid,
  output logic resp_err,
  output logic [31:0] resp_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [31:0] rx_data,
  output logic [7:0] bus_addr,
  output logic [15:0] bus_dout,
  output logic bus_doe,
  input wire logic [15:0] bus_din,
  output logic bus_cs_n,
  output logic bus_rd_n,
  output logic bus_wr_n
);
  localparam int STROBE_CYC = (`MHF_STROBE_NS + `MHF_CLK_NS - 1) / `MHF_CLK_NS;
  typedef struct packed {
    mhf_pkg::mhf_state_t st;
    mhf_pkg::mhf_state_t ret;
    logic skip;
    logic half;
    logic ph;
    logic [3:0] cnt;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] pmask;
    logic prd;
    logic pend;
    logic push;
    logic [12:0] words;
    logic [4:0] off;
    logic [1:0] pad;
    logic cmd_ready;
    logic resp_valid;
    logic resp_err;
    logic [31:0] resp_data;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic [7:0] a;
    logic [15:0] dout;
    logic doe;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } mhf_ctrl_st_t;
  mhf_ctrl_st_t q, d;
  logic fifo_ready;
  logic take;
  // ****************************************
  // Helpers
  // ****************************************
  function automatic mhf_ctrl_st_t start_acc(input mhf_ctrl_st_t s, input logic [7:0] addr, input logic wr,
                                             input logic [31:0] data, input mhf_pkg::mhf_state_t ret);
    mhf_ctrl_st_t r;
    r = s;
    r.st = mhf_pkg::S_ACC;
    r.ret = ret;
    r.addr = addr;
    r.wr = wr;
    r.wdata = data;
    r.half = 1'b0;
    r.ph = 1'b0;
    r.cnt = 4'h0;
    r.a = addr;
    r.dout = data[15:0];
    r.doe = wr;
    r.cs_n = 1'b0;
    r.rd_n = wr;
    r.wr_n = !wr;
    return r;
  endfunction : start_acc
  // Padding rounds each packet to a whole burst
  function automatic logic [12:0] dw_count(input logic [13:0] len, input logic [4:0] off, input logic [1:0] pad);
    logic [14:0] bytes;
    logic [12:0] dw;
    logic [12:0] m;
    bytes = {1'b0, len} + {10'h000, off};
    dw = 13'((bytes + 15'h0003) >> 2);
    m = (pad == 2'h1) ? 13'h0003 : (pad == 2'h2) ? 13'h0007 : 13'h0000;
    return (dw + m) & ~m;
  endfunction : dw_count
  function automatic logic [31:0] cfg_word(input logic [4:0] off, input logic [1:0] pad);
    return (32'(off) << `MHF_F_OFF_LO) | (32'(pad) << `MHF_F_PAD_LO);
  endfunction : cfg_word
  assign take = cmd_valid && q.cmd_ready;
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.din_s1 = bus_din;
    d.din_s2 = q.din_s1;
    d.resp_valid = 1'b0;
    d.push = 1'b0;
    unique case (q.st)
      mhf_pkg::S_IDLE: begin
        if (take) begin
          d.cmd_ready = 1'b0;
          d.resp_err = 1'b0;
          d.resp_data = 32'h0000_0000;
          d.prd = 1'b0;
          d.skip = (cmd_op == mhf_pkg::OP_RX_SKIP);
          case (cmd_op)
            mhf_pkg::OP_WR_REG: d = start_acc(d, cmd_addr, 1'b1, cmd_data, mhf_pkg::S_DONE);
            mhf_pkg::OP_RD_REG: d = start_acc(d, cmd_addr, 1'b0, 32'h0, mhf_pkg::S_DONE);
            mhf_pkg::OP_TX_WORD: d = start_acc(d, `MHF_A_TX_DATA, 1'b1, cmd_data, mhf_pkg::S_DONE);
            mhf_pkg::OP_TX_STOP: begin
              d.pmask = 32'h1 << `MHF_B_TX_ON;
              d = start_acc(d, `MHF_A_TX_CFG, 1'b1, (32'h1 << `MHF_B_TX_STOP) | (32'h1 << `MHF_B_TX_ON),
                            mhf_pkg::S_POLL);
            end
            mhf_pkg::OP_TX_START: d = start_acc(d, `MHF_A_TX_CFG, 1'b1, 32'h1 << `MHF_B_TX_ON, mhf_pkg::S_DONE);
            mhf_pkg::OP_RX_CFG: begin
              // Only taken when idle, so never inside a packet read
              d.off = cmd_data[4:0];
              d.pad = cmd_data[9:8];
              d = start_acc(d, `MHF_A_RX_CFG, 1'b1, cfg_word(cmd_data[4:0], cmd_data[9:8]), mhf_pkg::S_DONE);
            end
            mhf_pkg::OP_RX_PKT, mhf_pkg::OP_RX_SKIP: d = start_acc(d, `MHF_A_FIFO_LVL, 1'b0, 32'h0, mhf_pkg::S_LVL);
            mhf_pkg::OP_RX_DUMP: d = start_acc(d, `MHF_A_MAC_CR, 1'b0, 32'h0, mhf_pkg::S_CHK);
            default: d.st = mhf_pkg::S_ERR;
          endcase
        end
      end
      mhf_pkg::S_ACC: begin
        if (!q.ph) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(STROBE_CYC - 1)) begin
            d.ph = 1'b1;
            d.cs_n = 1'b1;
            d.rd_n = 1'b1;
            d.wr_n = 1'b1;
            d.doe = 1'b0;
            if (!q.wr && !q.half) d.rdata[15:0] = q.din_s2;
            if (!q.wr && q.half) d.rdata[31:16] = q.din_s2;
          end
        end else if (!q.half) begin
          // Low half first, then high half at the next halfword
          d.half = 1'b1;
          d.ph = 1'b0;
          d.cnt = 4'h0;
          d.a = q.addr + 8'h02;
          d.dout = q.wdata[31:16];
          d.doe = q.wr;
          d.cs_n = 1'b0;
          d.rd_n = q.wr;
          d.wr_n = !q.wr;
        end else begin
          d.half = 1'b0;
          d.st = q.ret;
        end
      end
      mhf_pkg::S_LVL: begin
        // Status must exist before anything is read
        if (q.rdata[`MHF_F_STUSED_LO +: 8] == 8'h00) d.st = mhf_pkg::S_ERR;
        else d = start_acc(d, `MHF_A_RX_STAT, 1'b0, 32'h0, mhf_pkg::S_STAT);
      end
      mhf_pkg::S_STAT: begin
        d.resp_data = q.rdata;
        d.words = dw_count(q.rdata[`MHF_F_LEN_LO +: 14], q.off, q.pad);
        d.pend = 1'b0;
        if (q.skip && d.words >= `MHF_FFWD_MIN_DW) begin
          d.pmask = 32'h1 << `MHF_B_FFWD;
          d = start_acc(d, `MHF_A_DP_CTRL, 1'b1, 32'h1 << `MHF_B_FFWD, mhf_pkg::S_POLL);
        end else if (d.words == 13'h0000) begin
          d.st = mhf_pkg::S_DONE;
        end else begin
          d.st = mhf_pkg::S_DATA;
        end
      end
      mhf_pkg::S_DATA: begin
        if (q.pend) begin
          d.pend = 1'b0;
          d.push = !q.skip;
          d.words = q.words - 13'h0001;
        end else if (q.words == 13'h0000) begin
          d.st = mhf_pkg::S_DONE;
        end else if (fifo_ready && !q.push) begin
          // Stall the device reads while the user holds back
          d = start_acc(d, `MHF_A_RX_DATA, 1'b0, 32'h0, mhf_pkg::S_DATA);
          d.pend = 1'b1;
        end
      end
      mhf_pkg::S_CHK: begin
        if (q.rdata[`MHF_B_RECEIVER_ENABLE_BIT]) begin
          d.st = mhf_pkg::S_ERR;
        end else begin
          d.pmask = 32'h1 << `MHF_B_RX_DUMP;
          d = start_acc(d, `MHF_A_RX_CFG, 1'b1, cfg_word(q.off, q.pad) | (32'h1 << `MHF_B_RX_DUMP), mhf_pkg::S_POLL);
        end
      end
      mhf_pkg::S_POLL: begin
        // Only the control register is read until the bit drops
        if (q.prd && ((q.rdata & q.pmask) == 32'h0)) begin
          d.st = mhf_pkg::S_DONE;
        end else begin
          d = start_acc(d, q.addr, 1'b0, 32'h0, mhf_pkg::S_POLL);
          d.prd = 1'b1;
        end
      end
      mhf_pkg::S_ERR: begin
        d.resp_err = 1'b1;
        d.st = mhf_pkg::S_DONE;
      end
      mhf_pkg::S_DONE: begin
        if (q.ret == mhf_pkg::S_DONE && !q.wr) d.resp_data = q.rdata;
        d.resp_valid = 1'b1;
        d.cmd_ready = 1'b1;
        d.st = mhf_pkg::S_IDLE;
      end
      default: d.st = mhf_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= mhf_pkg::S_IDLE;
      q.ret <= mhf_pkg::S_IDLE;
      q.off <= `MHF_RST_OFF;
      q.pad <= `MHF_RST_PAD;
      q.cmd_ready <= 1'b1;
      q.cs_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // ****************************************
  // Receive data buffer
  // ****************************************
  mhf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_mhf_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(q.push),
    .in_ready(fifo_ready),
    .in_data(q.rdata),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
  assign cmd_ready = q.cmd_ready;
  assign resp_valid = q.resp_valid;
  assign resp_err = q.resp_err;
  assign resp_data = q.resp_data;
  assign bus_addr = q.a;
  assign bus_dout = q.dout;
  assign bus_doe = q.doe;
  assign bus_cs_n = q.cs_n;
  assign bus_rd_n = q.rd_n;
  assign bus_wr_n = q.wr_n;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  half_pair_a: assert property ($fell(q.cs_n) && !q.half |-> ##[1:20] ($fell(q.cs_n) && q.half && q.a == q.addr + 8'h02))
    else $error("Low halfword not followed by high halfword");
  ffwd_noread_a: assert property (!q.rd_n && q.ret == mhf_pkg::S_POLL && q.pmask[`MHF_B_FFWD] |->
                                  {q.a[7:2], 2'h0} != `MHF_A_RX_DATA && {q.a[7:2], 2'h0} != `MHF_A_RX_STAT)
    else $error("Receive FIFO read while skip pending");
  ffwd_len_a: assert property (!q.wr_n && q.addr == `MHF_A_DP_CTRL && q.wdata[`MHF_B_FFWD] |-> q.words >= 13'h0004)
    else $error("Fast-forward on a short packet");
  dump_gate_a: assert property ($fell(q.wr_n) && q.addr == `MHF_A_RX_CFG && q.wdata[`MHF_B_RX_DUMP] |-> !q.rdata[`MHF_B_RECEIVER_ENABLE_BIT])
    else $error("Dump issued with receiver enabled");
  off_stable_a: assert property (q.st == mhf_pkg::S_DATA |=> $stable(q.off) && $stable(q.pad))
    else $error("Offset changed during packet read");
  underrun_a: assert property (q.st == mhf_pkg::S_LVL && q.rdata[`MHF_F_STUSED_LO +: 8] == 8'h00 |-> ##3 resp_valid && resp_err)
    else $error("Empty status not refused");
  stop_write_a: assert property (take && cmd_op == mhf_pkg::OP_TX_STOP |=> !q.wr_n && q.a == `MHF_A_TX_CFG ##1 q.ret == mhf_pkg::S_POLL)
    else $error("Stop request not written");
  fifo_room_a: assert property (q.push |-> fifo_ready)
    else $error("Push into full buffer");
  resp_pulse_a: assert property (resp_valid |-> cmd_ready ##1 !resp_valid)
    else $error("Answer longer than one cycle");
  pkt_done_c: cover property (q.st == mhf_pkg::S_DATA && q.words == 13'h0000 && !q.pend);
  ffwd_done_c: cover property (q.st == mhf_pkg::S_POLL && q.pmask[`MHF_B_FFWD] ##1 q.st == mhf_pkg::S_DONE);
  dump_done_c: cover property (q.st == mhf_pkg::S_POLL && q.pmask[`MHF_B_RX_DUMP] ##1 q.st == mhf_pkg::S_DONE);
  fifo_full_c: cover property (q.st == mhf_pkg::S_DATA && !fifo_ready);
endmodule : mhf_ctrl

// *** tb/mhf_dev.sv ***
// Purpose: Behavioural model of the Ethernet device FIFOs and registers
// Assumes: A halfword access completes when its strobe rises
// Notes: Acts on falling edges, clear of the controller's sampling edge
`timescale 1ns/1ps
`include "mhf_defs.svh"
module mhf_dev #(
  parameter int TX_CAP = 8,
  parameter int SLOW = 12
) (
  input wire logic clk,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_dout,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  output logic [15:0] bus_din
);
  logic [31:0] rxd[$];
  logic [31:0] rxs[$];
  int pkt[$];
  logic [31:0] cur = 32'h0, rx_cfg = 32'h0, tx_cfg = 32'h0, dp_ctrl = 32'h0, mac_cr = 32'h0;
  logic [15:0] last = 16'h0, lo = 16'h0, d_q = 16'h0;
  logic [7:0] a_q = 8'h0;
  logic rx_err = 1'b0, tx_err = 1'b0, stop_seen = 1'b0, rd_q = 1'b0, wr_q = 1'b0;
  logic [31:0] tx_a = 32'h0;
  int tx_used = 0;
  int wait_n = 0;
  wire sel = !bus_cs_n && !bus_rd_n;
  // Released bus shows the inverse of the last value, never a held copy
  assign bus_din = sel ? (bus_addr[1] ? cur[31:16] : cur[15:0]) : ~last;
  task automatic add_pkt(input int len, input logic [31:0] base);
    int dw;
    dw = (len + int'(rx_cfg[12:8]) + 3) / 4;
    if (rx_cfg[31:30] == 2'h1) dw = (dw + 3) / 4 * 4;
    if (rx_cfg[31:30] == 2'h2) dw = (dw + 7) / 8 * 8;
    for (int i = 0; i < dw; i++) rxd.push_back(base + i);
    pkt.push_back(dw);
    rxs.push_back({2'h0, len[13:0], 16'h0});
  endtask : add_pkt
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      `MHF_A_RX_DATA: return rxd.size() > 0 ? rxd[0] : 32'h0;
      `MHF_A_RX_STAT: return rxs.size() > 0 ? rxs[0] : 32'h0;
      `MHF_A_RX_CFG: return rx_cfg;
      `MHF_A_TX_CFG: return tx_cfg;
      `MHF_A_DP_CTRL: return dp_ctrl;
      `MHF_A_FIFO_LVL: return {8'h0, 8'(rxs.size()), 16'(rxd.size())};
      `MHF_A_MAC_CR: return mac_cr;
      default: return 32'h0;
    endcase
  endfunction : rd_word
  task automatic write_word(input logic [7:0] a, input logic [31:0] w);
    case (a)
      `MHF_A_TX_DATA: begin
        tx_used++;
        if (tx_used == 1) tx_a = w;
        // Single-buffer packet: buffer size must match packet length
        if (tx_used == 2 && tx_a[13] && tx_a[12]) tx_err |= (tx_a[10:0] != w[10:0]);
        tx_err |= (tx_used > TX_CAP);
      end
      `MHF_A_RX_CFG: begin
        rx_err |= w[15] & mac_cr[`MHF_B_RECEIVER_ENABLE_BIT];
        rx_cfg = w;
      end
      `MHF_A_TX_CFG: tx_cfg = w;
      `MHF_A_DP_CTRL: begin
        rx_err |= w[31] && (pkt.size() == 0 || pkt[0] < 4);
        dp_ctrl = w;
      end
      `MHF_A_MAC_CR: mac_cr = w;
      default: ;
    endcase
    if (w[31] || w[15] || w[0]) wait_n = SLOW;
  endtask : write_word
  always @(negedge clk) begin
    if (sel) last = bus_din;
    // High half only, so a word always moves whole
    if (rd_q && !sel && a_q == 8'h02) begin
      if (rxd.size() == 0 || dp_ctrl[31]) rx_err = 1'b1;
      else begin
        void'(rxd.pop_front());
        pkt[0]--;
        if (pkt[0] == 0) void'(pkt.pop_front());
      end
    end
    if (rd_q && !sel && a_q == 8'h42) begin
      if (rxs.size() == 0 || dp_ctrl[31]) rx_err = 1'b1;
      else void'(rxs.pop_front());
    end
    if (wr_q && bus_wr_n && !a_q[1]) lo = d_q;
    if (wr_q && bus_wr_n && a_q[1]) write_word({a_q[7:2], 2'h0}, {d_q, lo});
    // Slow completion so the controller really has to poll
    if (wait_n == 1) begin
      if (tx_cfg[0]) begin
        tx_cfg[1:0] = 2'h0;
        stop_seen = 1'b1;
      end
      if (dp_ctrl[31] && pkt.size() > 0) begin
        repeat (pkt[0]) void'(rxd.pop_front());
        void'(pkt.pop_front());
      end
      dp_ctrl[31] = 1'b0;
      if (rx_cfg[15]) begin
        rxd.delete();
        rxs.delete();
        pkt.delete();
      end
      rx_cfg[15] = 1'b0;
    end
    if (wait_n > 0) wait_n--;
    rd_q = sel;
    wr_q = !bus_cs_n && !bus_wr_n;
    a_q = bus_addr;
    d_q = bus_dout;
    cur = rd_word({bus_addr[7:2], 2'h0});
  end
endmodule : mhf_dev

// *** tb/mhf_ctrl_test.sv ***
// Purpose: Self-checking bench for the host side FIFO controller
// Assumes: Device model mhf_dev on the far side
// Notes: Inputs change on falling edges only
`timescale 1ns/1ps
`include "mhf_defs.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module mhf_ctrl_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  mhf_pkg::mhf_op_t cmd_op = mhf_pkg::OP_WR_REG;
  logic [7:0] cmd_addr = 8'h0;
  logic [31:0] cmd_data = 32'h0;
  logic rx_ready = 1'b1;
  logic cmd_ready, resp_valid, resp_err, rx_valid, bus_doe, bus_cs_n, bus_rd_n, bus_wr_n;
  logic [31:0] resp_data, rx_data;
  logic [7:0] bus_addr;
  logic [15:0] bus_dout, bus_din;
  logic [31:0] got[$];
  int bad_count = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  mhf_ctrl #(.FIFO_DEPTH(16)) u_mhf_ctrl (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
    .resp_valid, .resp_err, .resp_data, .rx_valid, .rx_ready, .rx_data, .bus_addr, .bus_dout, .bus_doe, .bus_din,
    .bus_cs_n, .bus_rd_n, .bus_wr_n);
  mhf_dev u_mhf_dev (.clk, .bus_addr, .bus_dout, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_din);
  // Sampled after the falling edge, once rx_ready has settled
  always @(negedge clk) begin
    #1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
  end
  // Data pins driven exactly while a write strobe is low
  always @(negedge clk) begin
    if (rstn && !bus_cs_n) `CHK("bus_doe", !bus_wr_n, bus_doe)
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic cmd(input mhf_pkg::mhf_op_t op, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK("resp_valid", 1'b1, resp_valid)
  endtask : cmd
  task automatic rx_words(input int cnt, input logic [31:0] base);
    int k;
    logic [31:0] w;
    k = 0;
    while (got.size() < cnt && k < 50) begin
      @(negedge clk);
      k++;
    end
    `CHK("rx count", cnt, got.size())
    for (int i = 0; i < cnt && got.size() > 0; i++) begin
      w = got.pop_front();
      `CHK("rx word", base + i, w)
    end
  endtask : rx_words
  task automatic rx_one(input logic [31:0] cfg, input int len, input logic [31:0] base, input int dw);
    cmd(mhf_pkg::OP_RX_CFG, 8'h0, cfg);
    u_mhf_dev.add_pkt(len, base);
    cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
    `CHK("status", {2'h0, len[13:0], 16'h0}, resp_data)
    rx_words(dw, base);
  endtask : rx_one
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    `CHK("cmd_ready", 1'b1, cmd_ready)
    `CHK("cs_n idle", 1'b1, bus_cs_n)
    `CHK("rx_valid", 1'b0, rx_valid)
    $display("test reset done");
    cmd(mhf_pkg::OP_WR_REG, `MHF_A_MAC_CR, 32'h4);
    cmd(mhf_pkg::OP_RD_REG, `MHF_A_MAC_CR, 32'h0);
    `CHK("mac_cr", 32'h4, resp_data)
    `CHK("resp_err", 1'b0, resp_err)
    $display("test registers done");
    cmd(mhf_pkg::OP_RX_CFG, 8'h0, 32'h2);
    u_mhf_dev.add_pkt(10, 32'h1000);
    u_mhf_dev.add_pkt(17, 32'h2000);
    cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
    `CHK("status", 32'h000a_0000, resp_data)
    rx_words(3, 32'h1000);
    cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
    `CHK("status", 32'h0011_0000, resp_data)
    rx_words(5, 32'h2000);
    $display("test offset done");
    rx_one(32'h100, 5, 32'h3000, 4);
    rx_one(32'h200, 4, 32'h4000, 8);
    rx_one(32'h1f, 1, 32'h5000, 8);
    $display("test padding done");
    cmd(mhf_pkg::OP_RX_CFG, 8'h0, 32'h0);
    u_mhf_dev.add_pkt(24, 32'h6000);
    u_mhf_dev.add_pkt(8, 32'h7000);
    u_mhf_dev.add_pkt(12, 32'h8000);
    cmd(mhf_pkg::OP_RX_SKIP, 8'h0, 32'h0);
    `CHK("skip status", 32'h0018_0000, resp_data)
    `CHK("ffwd clear", 1'b0, u_mhf_dev.dp_ctrl[31])
    cmd(mhf_pkg::OP_RX_SKIP, 8'h0, 32'h0);
    cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
    rx_words(3, 32'h8000);
    cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
    `CHK("empty refused", 1'b1, resp_err)
    $display("test skip done");
    cmd(mhf_pkg::OP_WR_REG, `MHF_A_TX_CFG, 32'h2);
    cmd(mhf_pkg::OP_TX_WORD, 8'h0, 32'h0000_3040);
    cmd(mhf_pkg::OP_TX_WORD, 8'h0, 32'h0040_0040);
    cmd(mhf_pkg::OP_TX_STOP, 8'h0, 32'h0);
    `CHK("tx stopped", 2'h0, u_mhf_dev.tx_cfg[1:0])
    `CHK("stop seen", 1'b1, u_mhf_dev.stop_seen)
    cmd(mhf_pkg::OP_TX_START, 8'h0, 32'h0);
    `CHK("tx on", 1'b1, u_mhf_dev.tx_cfg[1])
    $display("test transmit done");
    u_mhf_dev.add_pkt(8, 32'h9000);
    cmd(mhf_pkg::OP_RX_DUMP, 8'h0, 32'h0);
    `CHK("dump refused", 1'b1, resp_err)
    cmd(mhf_pkg::OP_WR_REG, `MHF_A_MAC_CR, 32'h0);
    cmd(mhf_pkg::OP_RX_DUMP, 8'h0, 32'h0);
    `CHK("dump ok", 1'b0, resp_err)
    `CHK("data flushed", 0, u_mhf_dev.rxd.size())
    `CHK("status flushed", 0, u_mhf_dev.rxs.size())
    $display("test dump done");
    cmd(mhf_pkg::OP_RX_CFG, 8'h0, 32'h0);
    u_mhf_dev.add_pkt(80, 32'ha000);
    @(negedge clk);
    rx_ready = 1'b0;
    fork
      cmd(mhf_pkg::OP_RX_PKT, 8'h0, 32'h0);
      begin
        repeat (500) @(negedge clk);
        `CHK("fifo full", 4, u_mhf_dev.rxd.size())
        `CHK("busy", 1'b0, cmd_ready)
        rx_ready = 1'b1;
      end
    join
    rx_words(20, 32'ha000);
    $display("test fill done");
    `CHK("no rx error", 1'b0, u_mhf_dev.rx_err)
    `CHK("no tx error", 1'b0, u_mhf_dev.tx_err)
    wrap_up();
  end
  initial begin
    #1000000;
    bad_count++;
    $display("[ERR] watchdog exp done got hang");
    wrap_up();
  end
endmodule : mhf_ctrl_test
